//--- src/mbox_ctrl_pkg.sv
// Purpose: Shared constants and types for the dual-port mailbox host controller
// Assumes: 200 MHz clock, APB register access, one controller per RAM port
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package mbox_ctrl_pkg;
	localparam int          ADDR_W        = 13;                  // Array address width
	localparam int          DATA_W        = 18;                  // Array data width
	localparam int          SEM_W         = 3;                   // Token address width
	localparam logic [12:0] LEFT_MAILBOX  = 13'h1ffe;            // Left port's mailbox
	localparam logic [12:0] RIGHT_MAILBOX = 13'h1fff;            // Right port's mailbox
	// Register offsets
	localparam logic [7:0]  REG_CTRL      = 8'h00;               // Command register
	localparam logic [7:0]  REG_ADDR      = 8'h04;               // Target address
	localparam logic [7:0]  REG_WDATA     = 8'h08;               // Write data
	localparam logic [7:0]  REG_RDATA     = 8'h0c;               // Read data
	localparam logic [7:0]  REG_STATUS    = 8'h10;               // Status
	// Command field positions in the command register
	localparam int          CMD_GO        = 0;                   // Start bit
	localparam int          CMD_WRITE     = 1;                   // 1 write, 0 read
	localparam int          CMD_TOKEN     = 2;                   // Token space access
	localparam int          CMD_INHIBIT   = 3;                   // Hold slave busy low
	localparam int          CMD_PRIMARY   = 4;                   // Primary mode select level
	// Status field positions
	localparam int          ST_BUSY       = 0;                   // Access in progress
	localparam int          ST_MAILBOX    = 1;                   // Own mailbox flag raised
	localparam int          ST_COLLIDE    = 2;                   // Busy seen on last access
	localparam int          ST_INIT       = 3;                   // Mailbox flag initialised
	// Access timing in ns and cycles
	localparam int          CLK_NS        = 5;                   // Clock period
	localparam int          SETTLE_NS     = 20;                  // Address to busy decision
	localparam int          PULSE_NS      = 20;                  // Strobe width
	localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	// Pin group toward one RAM port; strobes active low
	typedef struct packed {
		logic               port_select_n;                       // Array select
		logic               token_space_select_n;                // Token select
		logic               write_n;                             // Write strobe
		logic               out_enable_n;                        // Output enable
		logic               high_byte_strobe_n;                  // Upper byte lane
		logic               low_byte_strobe_n;                   // Lower byte lane
		logic [ADDR_W-1:0]  addr;                                // Address
	} port_pins_t;
endpackage : mbox_ctrl_pkg

//--- src/mbox_cycle_timer.sv
// Purpose: Down counter that times the phases of one RAM access
// Assumes: Load pulse starts a count, done is a level when zero
// Notes:   Width is checked to be at least 2 bits
`timescale 1ns/10ps
`default_nettype none
module mbox_cycle_timer #(
	parameter int WIDTH = 4                                      // Counter width
) (
	input  wire logic             clk_in,                        // Clock
	input  wire logic             arst_n_in,                     // Async reset, low
	input  wire logic             load_in,                       // Start a count
	input  wire logic [WIDTH-1:0] value_in,                      // Cycles to count
	output logic                  done_out                       // Count exhausted
);
	logic [WIDTH-1:0] count_q;                                   // Remaining cycles

	initial begin
		if (WIDTH < 2) $error("timer width too small");
	end

	// Load or count down to zero
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_q <= '0;
		end else if (load_in) begin
			count_q <= value_in;
		end else if (count_q != '0) begin
			count_q <= count_q - WIDTH'(1);
		end
	end

	// Done looks at the count only; gating it with the load would close a loop through the caller's load decode
	assign done_out = (count_q == '0);
endmodule : mbox_cycle_timer
`default_nettype wire

//--- src/mbox_port_host.sv
// Purpose: Host controller that drives one port of a two-port mailbox RAM
// Assumes: RAM pins sampled synchronously; software on APB gives orders
// Notes:   One access at a time; busy input stretches a cycle
//
// Function
// - Host holds secondary busy high normally
// - Hold address and select until busy settles
// - Exactly one primary in a wide array
// - Token access: port select high, token low
// - Host clears mailbox flags after power-up
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mbox_port_host #(
	parameter bit IS_LEFT = 1'b1                                 // Left port when set
) (
	input  wire logic                              clk_in,       // Clock
	input  wire logic                              arst_n_in,    // Async reset, low
	input  wire logic                              psel,         // APB select
	input  wire logic                              penable,      // APB enable
	input  wire logic                              pwrite,       // APB direction
	input  wire logic [7:0]                        paddr,        // APB address
	input  wire logic [31:0]                       pwdata,       // APB write data
	output logic      [31:0]                       prdata,       // APB read data
	output logic                                   pready,       // APB ready
	output logic                                   pslverr,      // APB error
	output mbox_ctrl_pkg::port_pins_t              pins_out,     // RAM control pins
	output logic      [mbox_ctrl_pkg::DATA_W-1:0]  data_out,     // Data pin drive
	output logic                                   data_oe_out,  // Data pin enable
	input  wire logic [mbox_ctrl_pkg::DATA_W-1:0]  data_in,      // Data pin level
	input  wire logic                              busy_n_in,    // Busy pin level
	output logic                                   busy_n_out,   // Busy drive, secondary
	output logic                                   busy_oe_out,  // Busy pin enable
	input  wire logic                              mailbox_n_in, // Own mailbox flag
	output logic                                   primary_out   // Primary select level
);
	typedef enum logic [2:0] {IDLE, SETTLE, STROBE, RECOVER, INIT} state_t;

	localparam logic [12:0] OWN_BOX = IS_LEFT ? mbox_ctrl_pkg::LEFT_MAILBOX : mbox_ctrl_pkg::RIGHT_MAILBOX;

	state_t                             state_q;                 // Access sequencer
	logic [12:0]                        addr_q;                  // Target address
	logic [mbox_ctrl_pkg::DATA_W-1:0]   wdata_q;                 // Write data
	logic [mbox_ctrl_pkg::DATA_W-1:0]   rdata_q;                 // Last read data
	logic                               write_q;                 // Current access writes
	logic                               token_q;                 // Current access in token space
	logic                               inhibit_q;               // Secondary write block
	logic                               primary_q;               // Primary mode level
	logic                               collide_q;               // Busy seen this access
	logic                               init_done_q;             // Mailbox cleared once
	logic                               timer_load;              // Start a phase
	logic [3:0]                         timer_val;               // Phase length
	logic                               timer_done;              // Phase over
	logic                               wr_acc;                  // APB write access phase
	logic                               go;                      // Software starts access
	logic                               settled;                 // Settle over, not held off

	assign wr_acc = psel && penable && pwrite;
	assign go     = wr_acc && (paddr == mbox_ctrl_pkg::REG_CTRL) && pwdata[mbox_ctrl_pkg::CMD_GO]
	                && (state_q == IDLE);

	// In secondary mode the busy pin carries our own inhibit drive, so only a primary may hold us off
	assign settled = timer_done && (busy_n_in || !primary_q);

	mbox_cycle_timer #(.WIDTH(4)) u_timer (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.load_in   (timer_load),
		.value_in  (timer_val),
		.done_out  (timer_done)
	);

	// Phase loads: settle on entry, strobe after settle, recover after strobe
	always_comb begin
		timer_load = 1'b0;
		timer_val  = 4'(mbox_ctrl_pkg::SETTLE_CYC);
		if (go || (state_q == IDLE && !init_done_q)) begin
			timer_load = 1'b1;
		end else if ((state_q == SETTLE || state_q == INIT) && settled) begin
			timer_load = 1'b1;
			timer_val  = 4'(mbox_ctrl_pkg::PULSE_CYC);
		end else if (state_q == STROBE && timer_done) begin
			timer_load = 1'b1;
		end
	end

	// Sequencer: power-up mailbox clear, then software accesses
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= IDLE;
		end else begin
			unique case (state_q)
				IDLE: begin
					if (!init_done_q) state_q <= INIT;
					else if (go) state_q <= SETTLE;
				end
				// Hold address and select until busy decision is out
				SETTLE, INIT: begin
					if (settled) state_q <= STROBE;
				end
				STROBE: begin
					if (timer_done) state_q <= RECOVER;
				end
				RECOVER: begin
					if (timer_done) state_q <= IDLE;
				end
			endcase
		end
	end

	// Latch command fields on start; init does a read of own mailbox
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			addr_q  <= '0;
			write_q <= 1'b0;
			token_q <= 1'b0;
		end else if (state_q == IDLE && !init_done_q) begin
			addr_q  <= OWN_BOX;
			write_q <= 1'b0;
			token_q <= 1'b0;
		end else if (wr_acc && paddr == mbox_ctrl_pkg::REG_ADDR && state_q == IDLE) begin
			addr_q  <= pwdata[12:0];
		end else if (go) begin
			write_q <= pwdata[mbox_ctrl_pkg::CMD_WRITE];
			token_q <= pwdata[mbox_ctrl_pkg::CMD_TOKEN];
		end
	end

	// Mode bits and write data
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			inhibit_q <= 1'b0;
			primary_q <= 1'b1;
			wdata_q   <= '0;
		end else if (wr_acc && state_q == IDLE) begin
			if (paddr == mbox_ctrl_pkg::REG_CTRL) begin
				inhibit_q <= pwdata[mbox_ctrl_pkg::CMD_INHIBIT];
				primary_q <= pwdata[mbox_ctrl_pkg::CMD_PRIMARY];
			end
			if (paddr == mbox_ctrl_pkg::REG_WDATA) wdata_q <= pwdata[17:0];
		end
	end

	// Read capture at strobe end, collision and init tracking
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_q     <= '0;
			collide_q   <= 1'b0;
			init_done_q <= 1'b0;
		end else begin
			if (state_q == STROBE && timer_done && !write_q) rdata_q <= data_in;
			if (go) collide_q <= 1'b0;
			else if (state_q != IDLE && !busy_n_in) collide_q <= 1'b1;
			if (state_q == RECOVER && timer_done) init_done_q <= 1'b1;
		end
	end

	// Pin drive: select by space, write and output enables only in strobe phase, byte strobes in every non-idle state
	always_comb begin
		pins_out                      = '0;
		pins_out.addr                 = token_q ? {10'h000, addr_q[2:0]} : addr_q;
		pins_out.port_select_n        = !(state_q != IDLE && !token_q);
		pins_out.token_space_select_n = !(state_q != IDLE && token_q);
		pins_out.write_n              = !(state_q == STROBE && write_q);
		pins_out.out_enable_n         = !(state_q == STROBE && !write_q);
		pins_out.high_byte_strobe_n   = state_q == IDLE;
		pins_out.low_byte_strobe_n    = state_q == IDLE;
	end

	// Data pin drive; token writes use bit 0 only
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			data_out    <= '0;
			data_oe_out <= 1'b0;
		end else begin
			data_out    <= token_q ? {17'h00000, wdata_q[0]} : wdata_q;
			data_oe_out <= write_q && (state_q == SETTLE || state_q == STROBE);
		end
	end

	// Busy pin is driven only when this port's RAM is secondary
	assign busy_oe_out = !primary_q;
	assign busy_n_out  = !inhibit_q;
	assign primary_out = primary_q;

	// APB slave: zero wait, unmapped offsets error
	assign pready = 1'b1;
	always_comb begin
		prdata  = '0;
		pslverr = 1'b0;
		unique case (paddr)
			mbox_ctrl_pkg::REG_CTRL:   prdata = {27'h0, primary_q, inhibit_q, token_q, write_q, 1'b0};
			mbox_ctrl_pkg::REG_ADDR:   prdata = {19'h0, addr_q};
			mbox_ctrl_pkg::REG_WDATA:  prdata = {14'h0, wdata_q};
			mbox_ctrl_pkg::REG_RDATA:  prdata = {14'h0, rdata_q};
			mbox_ctrl_pkg::REG_STATUS: prdata = {28'h0, init_done_q, collide_q, !mailbox_n_in, state_q != IDLE};
			default:                   pslverr = psel && penable;
		endcase
	end

	property p_strobe_after_settle;
		@(posedge clk_in) disable iff (!arst_n_in)
		$fell(pins_out.write_n) |-> ($past(busy_n_in) || !primary_q) && !pins_out.port_select_n == !token_q;
	endproperty
	a_strobe_after_settle: assert property (p_strobe_after_settle) else $error("strobe before busy settled");

	property p_token_selects;
		@(posedge clk_in) disable iff (!arst_n_in)
		!pins_out.token_space_select_n |-> pins_out.port_select_n;
	endproperty
	a_token_selects: assert property (p_token_selects) else $error("both selects active");

	property p_secondary_busy;
		@(posedge clk_in) disable iff (!arst_n_in)
		!primary_q && !inhibit_q |-> busy_oe_out && busy_n_out;
	endproperty
	a_secondary_busy: assert property (p_secondary_busy) else $error("secondary busy not held high");

	// Held off by the primary's busy decision during settle
	sequence s_held_off;
		state_q == SETTLE && primary_q && !busy_n_in;
	endsequence

	// No strobe and no address move while held off
	property p_hold_while_busy;
		@(posedge clk_in) disable iff (!arst_n_in)
		s_held_off |=> pins_out.write_n && pins_out.out_enable_n && $stable(pins_out.addr);
	endproperty
	a_hold_while_busy: assert property (p_hold_while_busy) else $error("strobe or address moved while busy");

	// Power-up access is a plain read of the own mailbox
	property p_init_clear;
		@(posedge clk_in) disable iff (!arst_n_in)
		state_q == INIT |-> pins_out.addr == OWN_BOX && pins_out.write_n && !pins_out.port_select_n;
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("init access not a mailbox read");

	// Idle port stays in standby
	property p_idle_standby;
		@(posedge clk_in) disable iff (!arst_n_in)
		state_q == IDLE |-> pins_out.port_select_n && pins_out.token_space_select_n && pins_out.write_n;
	endproperty
	a_idle_standby: assert property (p_idle_standby) else $error("port selected while idle");
endmodule : mbox_port_host
`default_nettype wire

//--- dv/mbox_ram_model.sv
// Purpose: Behavioural two-port mailbox RAM facing the two host controllers
// Assumes: Hosts move their pins just after rising clock edges
// Notes:   Writes land as the strobe rises; mailbox flags start raised
`timescale 1ns/10ps
`default_nettype none
module mbox_ram_model (
	input  wire logic                      clk_in,      // Sample clock
	input  wire logic                      arst_n_in,   // Reset, low
	input  wire mbox_ctrl_pkg::port_pins_t pins_in [2], // Port pins, 0 left
	input  wire logic [17:0]               hd_in [2],   // Host data drive
	input  wire logic [1:0]                hoe_in,      // Host data enable
	input  wire logic [1:0]                hb_in,       // Host busy drive
	input  wire logic [1:0]                hboe_in,     // Host busy enable
	input  wire logic                      primary_in,  // Primary select
	output wire logic [17:0]               lvl_out [2], // Data pin level
	output wire logic [1:0]                busy_n_out,  // Busy pin level
	output wire logic [1:0]                flag_n_out   // Mailbox flags, low
);
	localparam logic [12:0] MB [2] = '{mbox_ctrl_pkg::LEFT_MAILBOX, mbox_ctrl_pkg::RIGHT_MAILBOX};
	logic [17:0] mem [8192];                 // Array
	logic [7:0]  own [2], req [2];           // Token held, request pending
	logic [17:0] wd [2], tl [2], lq [2];     // Write data, token latch, last level
	logic [1:0]  fl, wp, ok, ta;             // Flags, strobe, write allowed, token read
	realtime     t0 = 0, t1 = 0;             // Time each port last settled
	wire m = !pins_in[0].port_select_n && !pins_in[1].port_select_n && pins_in[0].addr == pins_in[1].addr;
	always @(pins_in[0].port_select_n, pins_in[0].addr) t0 = $realtime;
	always @(pins_in[1].port_select_n, pins_in[1].addr) t1 = $realtime;
	// Later port loses; a tie still busies one side only
	wire [1:0] bz = (primary_in && m) ? {t1 >= t0, t1 < t0} : 2'b00;
	assign flag_n_out = ~fl;
	// Released data lines show the inverse of their last level
	for (genvar i = 0; i < 2; i++) begin : g_pin
		assign busy_n_out[i] = primary_in ? !bz[i] : (!hboe_in[i] || hb_in[i]);
		assign lvl_out[i] = hoe_in[i] ? hd_in[i] : (!pins_in[i].out_enable_n && !pins_in[i].port_select_n)
			? mem[pins_in[i].addr] : (!pins_in[i].out_enable_n && !pins_in[i].token_space_select_n) ? tl[i] : ~lq[i];
	end
	// Commits writes, moves tokens and flags
	always @(posedge clk_in or negedge arst_n_in) begin
		logic [12:0] a;
		logic [2:0]  k;
		if (!arst_n_in) begin
			own = '{8'h00, 8'h00};
			req = '{8'h00, 8'h00};
			fl <= 2'b11;
			wp = 2'b11;
			ta = 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				a = pins_in[i].addr;
				k = a[2:0];
				if (!pins_in[i].write_n) begin
					wd[i] = lvl_out[i];
					ok[i] = busy_n_out[i];
				end else if (!wp[i] && ok[i]) begin
					if (!pins_in[i].port_select_n) begin
						mem[a] <= wd[i];
						if (a == MB[1 - i]) fl[1 - i] <= 1'b1;
					end else if (!pins_in[i].token_space_select_n) begin
						if (!wd[i][0]) begin
							if (own[1 - i][k]) req[i][k] = 1'b1;
							else own[i][k] = 1'b1;
						end else if (own[i][k]) begin
							own[i][k] = 1'b0;
							own[1 - i][k] = req[1 - i][k];
							req[1 - i][k] = 1'b0;
						end else req[i][k] = 1'b0;
					end
				end
				if (!pins_in[i].port_select_n && !pins_in[i].out_enable_n && a == MB[i]) fl[i] <= 1'b0;
				if (!pins_in[i].token_space_select_n && !pins_in[i].out_enable_n) begin
					if (!ta[i]) tl[i] <= {18{!own[i][k]}};
					ta[i] = 1'b1;
				end else ta[i] = 1'b0;
				wp[i] = pins_in[i].write_n;
				lq[i] <= lvl_out[i];
			end
		end
	end
endmodule : mbox_ram_model
`default_nettype wire

//--- dv/tb_mbox_port_host.sv
// Purpose: Self-checking bench for a left and a right host on one RAM model
// Assumes: APB answers with no wait state
// Notes:   Each scenario task drives APB and judges its own results
`timescale 1ns/10ps
`default_nettype none
module tb_mbox_port_host;
	localparam logic [12:0] MB [2] = '{mbox_ctrl_pkg::LEFT_MAILBOX, mbox_ctrl_pkg::RIGHT_MAILBOX};
	logic        clk_in = 1'b0, arst_n_in = 1'b0;
	logic [1:0]  psel = 2'b00, penable = 2'b00, pwrite = 2'b00;
	logic [7:0]  paddr [2] = '{8'h00, 8'h00};
	logic [31:0] pwdata [2] = '{32'h0000_0000, 32'h0000_0000};
	wire  [31:0] prdata [2];
	wire  [17:0] dout [2], lvl [2];
	wire  [1:0]  pready, pslverr, doe, bo, boe, prim, busy_n, flag_n;
	wire mbox_ctrl_pkg::port_pins_t pins [2];
	int          mismatches = 0, n_tests = 0;
	logic [31:0] r;                          // Last read word
	logic        e;                          // Last error flag
	initial forever #2.5 clk_in = ~clk_in;
	for (genvar i = 0; i < 2; i++) begin : g_h
		mbox_port_host #(.IS_LEFT(i == 0)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel(psel[i]),
			.penable(penable[i]), .pwrite(pwrite[i]), .paddr(paddr[i]), .pwdata(pwdata[i]), .prdata(prdata[i]),
			.pready(pready[i]), .pslverr(pslverr[i]), .pins_out(pins[i]), .data_out(dout[i]), .data_oe_out(doe[i]),
			.data_in(lvl[i]), .busy_n_in(busy_n[i]), .busy_n_out(bo[i]), .busy_oe_out(boe[i]),
			.mailbox_n_in(flag_n[i]), .primary_out(prim[i]));
	end
	mbox_ram_model ram (.clk_in(clk_in), .arst_n_in(arst_n_in), .pins_in(pins), .hd_in(dout), .hoe_in(doe),
		.hb_in(bo), .hboe_in(boe), .primary_in(prim[0]), .lvl_out(lvl), .busy_n_out(busy_n), .flag_n_out(flag_n));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		n_tests++;
		if (s !== x) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	// One APB transfer, entered just after a rising edge
	task automatic apb(input int p, input bit w, input logic [7:0] a, input logic [31:0] d);
		psel[p] <= 1'b1;
		pwrite[p] <= w;
		paddr[p] <= a;
		pwdata[p] <= d;
		@(posedge clk_in) penable[p] <= 1'b1;
		do @(posedge clk_in); while (pready[p] !== 1'b1);
		r = prdata[p];
		e = pslverr[p];
		psel[p] <= 1'b0;
		penable[p] <= 1'b0;
		@(posedge clk_in);
	endtask : apb
	task automatic stat(input int p);
		apb(p, 0, mbox_ctrl_pkg::REG_STATUS, 32'h0000_0000);
	endtask : stat
	// One RAM access; c is {primary, inhibit, token, write}
	task automatic acc(input int p, input logic [3:0] c, input logic [12:0] a, input logic [17:0] d);
		apb(p, 1, mbox_ctrl_pkg::REG_ADDR, {19'h0, a});
		apb(p, 1, mbox_ctrl_pkg::REG_WDATA, {14'h0, d});
		apb(p, 1, mbox_ctrl_pkg::REG_CTRL, {27'h0, c, 1'b1});
		do stat(p); while (r[0] !== 1'b0);
		apb(p, 0, mbox_ctrl_pkg::REG_RDATA, 32'h0000_0000);
	endtask : acc
	task automatic t_init;
		for (int p = 0; p < 2; p++) begin
			do stat(p); while (r[3] !== 1'b1);
			chk("status after init", 32'h0000_0008, {28'h0, r[3:0]});
			apb(p, 0, 8'h14, 32'h0000_0000);
			chk("unmapped error", 32'h0000_0001, {31'h0, e});
		end
	endtask : t_init
	task automatic t_mail;
		for (int p = 0; p < 2; p++) begin
			acc(1 - p, 4'h9, MB[p], 18'h2_a5c3 ^ p);
			stat(p);
			chk("flag raised", 32'h0000_0001, {31'h0, r[1]});
			acc(p, 4'h8, MB[p], 18'h0_0000);
			chk("mailbox data", 32'h0002_a5c3 ^ p, r);
			stat(p);
			chk("flag cleared", 32'h0000_0000, {31'h0, r[1]});
		end
	endtask : t_mail
	task automatic t_tok;
		logic [3:0] s [10] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hd, 4'h7, 4'ha, 4'hf, 4'h1, 4'h7};
		for (int n = 0; n < 10; n++) begin
			acc(s[n][3], 4'hb, 13'h0005, {17'h1_ffff, s[n][2]});
			for (int q = 0; q < 2; q++) begin
				acc(q, 4'ha, 13'h0005, 18'h0_0000);
				chk("token sequence", {14'h0, {18{s[n][1 - q]}}}, r);
			end
		end
		for (int k = 0; k < 8; k++) begin
			acc(1, 4'ha, k[12:0], 18'h0_0000);
			chk("token free", 32'h0003_ffff, r);
			acc(0, 4'hb, k[12:0], 18'h0_0000);
			acc(1, 4'ha, k[12:0], 18'h0_0000);
			chk("token taken", 32'h0003_ffff, r);
			acc(0, 4'ha, k[12:0], 18'h0_0000);
			chk("token held", 32'h0000_0000, r);
			acc(0, 4'hb, k[12:0], 18'h0_0001);
		end
	endtask : t_tok
	task automatic t_sec;
		acc(0, 4'h9, 13'h0123, 18'h1_1111);
		apb(0, 1, mbox_ctrl_pkg::REG_CTRL, 32'h0000_0000);
		chk("busy pin driven", 32'h0000_0001, {31'h0, boe[0]});
		acc(1, 4'h5, 13'h0123, 18'h2_2222);
		acc(0, 4'h0, 13'h0123, 18'h0_0000);
		chk("inhibited write", 32'h0001_1111, r);
		acc(1, 4'h1, 13'h0123, 18'h2_2222);
		acc(0, 4'h0, 13'h0123, 18'h0_0000);
		chk("secondary write", 32'h0002_2222, r);
		apb(0, 1, mbox_ctrl_pkg::REG_CTRL, 32'h0000_0010);
		apb(1, 1, mbox_ctrl_pkg::REG_CTRL, 32'h0000_0010);
		chk("busy pin released", 32'h0000_0000, {31'h0, boe[0]});
	endtask : t_sec
	task automatic t_col;
		for (int p = 0; p < 2; p++) apb(p, 1, mbox_ctrl_pkg::REG_ADDR, 32'h0000_0456);
		apb(1, 0, mbox_ctrl_pkg::REG_ADDR, 32'h0000_0000);
		chk("address readback", 32'h0000_0456, r);
		apb(0, 1, mbox_ctrl_pkg::REG_CTRL, 32'h0000_0011);
		apb(1, 1, mbox_ctrl_pkg::REG_CTRL, 32'h0000_0011);
		for (int p = 0; p < 2; p++) begin
			do stat(p); while (r[0] !== 1'b0);
			chk("collision seen", p, {31'h0, r[2]});
		end
	endtask : t_col
	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		t_init();
		t_mail();
		t_tok();
		t_sec();
		t_col();
		give_verdict();
	end
	// Cuts a hang short
	initial begin
		repeat (40000) @(posedge clk_in);
		mismatches++;
		give_verdict();
	end
endmodule : tb_mbox_port_host
`default_nettype wire
